/* rtl/flash_pkg.sv */
// Shared constants and types for the flash command-write and reset link
package flash_pkg;

   // ==========================================================
   // Bus widths
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int UNLOCK_W = 12;

   // ==========================================================
   // Timing, in printed units, then in cycles of ref_clk_i
   localparam int CLK_PERIOD_NS = 50;
   localparam int RST_PULSE_NS = 500;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_HIGH_NS = 200;
   localparam int RST_HIGH_CYC = (RST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STANDBY_US = 20;
   localparam int STANDBY_CYC = (STANDBY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_US = 8;
   localparam int PROG_CYC = PROG_US * 1000 / CLK_PERIOD_NS;
   localparam int SECTOR_ERASE_MS = 400;
   localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * (1000000 / CLK_PERIOD_NS);
   localparam int CHIP_ERASE_S = 28;
   localparam int CHIP_ERASE_CYC = CHIP_ERASE_S * (1000000000 / CLK_PERIOD_NS);
   localparam int STEP_CYC = 4;

   // ==========================================================
   // Command words; only the low address bits are compared
   localparam logic [UNLOCK_W-1:0] UL_ADDR1 = 12'h555;
   localparam logic [UNLOCK_W-1:0] UL_ADDR2 = 12'h2aa;
   localparam logic [DATA_W-1:0] UL_DATA1 = 16'h00aa;
   localparam logic [DATA_W-1:0] UL_DATA2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_PROG = 16'h00a0;
   localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
   localparam logic [DATA_W-1:0] CMD_SECT = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
   localparam int STATUS_TOGGLE_BIT = 6;

   // ==========================================================
   // Synchronised pin vector layout and idle level
   localparam int PIN_W = 6;
   localparam int P_CS = 5;
   localparam int P_AVD = 4;
   localparam int P_WE = 3;
   localparam int P_OE = 2;
   localparam int P_CLK = 1;
   localparam int P_RST = 0;
   localparam logic [PIN_W-1:0] PIN_IDLE = 6'h3d;

   typedef enum logic [1:0] {OP_PROG, OP_SECT, OP_CHIP} op_kind_t;

endpackage

/* rtl/flash_if.sv */
// Flash bus pins between the host controller and the flash device
`timescale 1ns/1ns
`default_nettype none
interface flash_if;
   import flash_pkg::*;
   logic cs_n;
   logic addr_valid_strobe_n;
   logic we_n;
   logic oe_n;
   logic flash_clk;
   logic reset_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;

   modport host (output cs_n, addr_valid_strobe_n, we_n, oe_n, flash_clk, reset_n,
      addr, wdata, input rdata);
   modport dev (input cs_n, addr_valid_strobe_n, we_n, oe_n, flash_clk, reset_n,
      addr, wdata, output rdata);
endinterface
`default_nettype wire

/* rtl/flash_dev.sv */
// Flash device end: write address capture, command decode, hardware reset
//
// What this block and the host do
// - Reset during busy aborts, back to read
// - Reset while idle returns to read quickly
// - Host waits after reset before reading
// - Long reset low enters standby
// - Async mode: address taken on write fall
// - Clocked mode: address on first strobe/clock
// - Unlock cycles compare only low address bits
// - Program handling ignores read-mode selection
// - Host raises select or strobe between sequences
// - Host gives no clock edge during write
// - Host toggles strobe every unlock cycle
// - Erase lasts 0.4 s sector, 28 s chip
// - Status needs two reads, strobe toggled
`timescale 1ns/1ns
`default_nettype none
module flash_dev
   import flash_pkg::*;
#(
   parameter int PROG_TIME_CYC = PROG_CYC,
   parameter int SECT_TIME_CYC = SECTOR_ERASE_CYC,
   parameter int CHIP_TIME_CYC = CHIP_ERASE_CYC,
   parameter int STANDBY_TIME_CYC = STANDBY_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   flash_if.dev bus,
   input wire logic sync_mode_i,
   output logic busy_o,
   output logic read_mode_o,
   output logic standby_o,
   output logic op_start_o,
   output logic op_done_o,
   output logic op_abort_o,
   output op_kind_t op_kind_o,
   output logic [ADDR_W-1:0] op_addr_o,
   output logic [DATA_W-1:0] op_data_o
);

   typedef enum logic [2:0] {
      S_READ, S_UL1, S_UL2, S_PROG_ARG, S_ER0, S_ER1, S_ER2, S_BUSY
   } dev_state_t;

   // ==========================================================
   // Pin synchronisers
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_s;
   logic [PIN_W-1:0] pin_prev;
   logic [ADDR_W-1:0] addr_meta;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_meta;
   logic [DATA_W-1:0] data_s;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_meta <= PIN_IDLE;
         pin_s <= PIN_IDLE;
         pin_prev <= PIN_IDLE;
      end else begin
         pin_meta <= {bus.cs_n, bus.addr_valid_strobe_n, bus.we_n, bus.oe_n,
            bus.flash_clk, bus.reset_n};
         pin_s <= pin_meta;
         pin_prev <= pin_s;
      end
   end

   // Address and data take the same two stages so they line up with strobes
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         addr_meta <= '0;
         addr_s <= '0;
         data_meta <= '0;
         data_s <= '0;
      end else begin
         addr_meta <= bus.addr;
         addr_s <= addr_meta;
         data_meta <= bus.wdata;
         data_s <= data_meta;
      end
   end

   logic sel;
   logic hw_reset;
   logic we_fall;
   logic we_rise;
   logic avd_fall;
   logic avd_rise;
   logic clk_rise;
   logic oe_fall;
   logic cs_rise;

   always_comb begin
      sel = !pin_s[P_CS];
      hw_reset = !pin_s[P_RST];
      we_fall = pin_prev[P_WE] && !pin_s[P_WE];
      we_rise = !pin_prev[P_WE] && pin_s[P_WE];
      avd_fall = pin_prev[P_AVD] && !pin_s[P_AVD];
      avd_rise = !pin_prev[P_AVD] && pin_s[P_AVD];
      clk_rise = !pin_prev[P_CLK] && pin_s[P_CLK];
      oe_fall = pin_prev[P_OE] && !pin_s[P_OE];
      cs_rise = !pin_prev[P_CS] && pin_s[P_CS];
   end

   // ==========================================================
   // Write address capture
   logic [ADDR_W-1:0] addr_lat;
   logic addr_taken;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         addr_lat <= '0;
         addr_taken <= 1'b0;
      end else if (!sync_mode_i) begin
         addr_taken <= 1'b0;
         if (sel && we_fall) begin
            addr_lat <= addr_s;
         end
      end else if (avd_fall || cs_rise) begin
         addr_taken <= 1'b0;
      end else if (sel && !addr_taken && (avd_rise || (clk_rise && !pin_s[P_AVD]))) begin
         addr_lat <= addr_s;
         addr_taken <= 1'b1;
      end
   end

   // Data lands on the write rising edge; decode a cycle later on stable pair
   logic [DATA_W-1:0] wr_data;
   logic wr_stb;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_data <= '0;
         wr_stb <= 1'b0;
      end else begin
         wr_stb <= sel && we_rise && !hw_reset;
         if (sel && we_rise) begin
            wr_data <= data_s;
         end
      end
   end

   // ==========================================================
   // Command decode and embedded operation timer
   dev_state_t state;
   logic [31:0] timer;
   logic ul_a1;
   logic ul_a2;

   // Upper address bits play no part in unlock matching
   always_comb begin
      ul_a1 = addr_lat[UNLOCK_W-1:0] == UL_ADDR1;
      ul_a2 = addr_lat[UNLOCK_W-1:0] == UL_ADDR2;
   end

   // The decoder has no read-mode input at all, so both write forms match
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= S_READ;
         timer <= '0;
         op_kind_o <= OP_PROG;
         op_addr_o <= '0;
         op_data_o <= '0;
         op_start_o <= 1'b0;
         op_done_o <= 1'b0;
         op_abort_o <= 1'b0;
      end else begin
         op_start_o <= 1'b0;
         op_done_o <= 1'b0;
         op_abort_o <= 1'b0;
         if (hw_reset) begin
            // Abort at once: well inside both reset-to-read limits
            op_abort_o <= state == S_BUSY;
            state <= S_READ;
            timer <= '0;
         end else if (state == S_BUSY) begin
            if (timer == 32'h0) begin
               state <= S_READ;
               op_done_o <= 1'b1;
            end else begin
               timer <= timer - 32'h1;
            end
         end else if (wr_stb) begin
            state <= S_READ;
            unique case (state)
               S_READ: begin
                  if (ul_a1 && wr_data == UL_DATA1) state <= S_UL1;
               end
               S_UL1: begin
                  if (ul_a2 && wr_data == UL_DATA2) state <= S_UL2;
               end
               S_UL2: begin
                  if (ul_a1 && wr_data == CMD_PROG) state <= S_PROG_ARG;
                  if (ul_a1 && wr_data == CMD_ERASE) state <= S_ER0;
               end
               S_PROG_ARG: begin
                  state <= S_BUSY;
                  timer <= 32'(PROG_TIME_CYC - 1);
                  op_kind_o <= OP_PROG;
                  op_addr_o <= addr_lat;
                  op_data_o <= wr_data;
                  op_start_o <= 1'b1;
               end
               S_ER0: begin
                  if (ul_a1 && wr_data == UL_DATA1) state <= S_ER1;
               end
               S_ER1: begin
                  if (ul_a2 && wr_data == UL_DATA2) state <= S_ER2;
               end
               S_ER2: begin
                  // Erase time excludes the preprogramming pass
                  if (wr_data == CMD_SECT) begin
                     state <= S_BUSY;
                     timer <= 32'(SECT_TIME_CYC - 1);
                     op_kind_o <= OP_SECT;
                     op_addr_o <= addr_lat;
                     op_data_o <= wr_data;
                     op_start_o <= 1'b1;
                  end else if (ul_a1 && wr_data == CMD_CHIP) begin
                     state <= S_BUSY;
                     timer <= 32'(CHIP_TIME_CYC - 1);
                     op_kind_o <= OP_CHIP;
                     op_addr_o <= addr_lat;
                     op_data_o <= wr_data;
                     op_start_o <= 1'b1;
                  end
               end
               S_BUSY: begin
                  state <= S_BUSY;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Status reads: bit toggles per read while busy
   logic toggle;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         toggle <= 1'b0;
         bus.rdata <= '0;
      end else if (sel && oe_fall) begin
         bus.rdata <= '0;
         if (state == S_BUSY) begin
            toggle <= !toggle;
            bus.rdata[STATUS_TOGGLE_BIT] <= !toggle;
         end else begin
            bus.rdata[STATUS_TOGGLE_BIT] <= toggle;
         end
      end
   end

   // ==========================================================
   // Standby after a long reset
   logic [31:0] low_cnt;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         low_cnt <= '0;
         standby_o <= 1'b0;
      end else if (!hw_reset) begin
         low_cnt <= '0;
         standby_o <= 1'b0;
      end else if (low_cnt >= 32'(STANDBY_TIME_CYC - 1)) begin
         standby_o <= 1'b1;
      end else begin
         low_cnt <= low_cnt + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         read_mode_o <= 1'b1;
      end else begin
         busy_o <= state == S_BUSY;
         read_mode_o <= state != S_BUSY;
      end
   end

endmodule // flash_dev
`default_nettype wire

/* rtl/flash_host.sv */
// Host controller end: issues command sequences, polls status, drives reset
`timescale 1ns/1ns
`default_nettype none
module flash_host
   import flash_pkg::*;
#(
   parameter int STEP_TIME_CYC = STEP_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   flash_if.host bus,
   input wire logic sync_mode_i,
   input wire logic cmd_valid_i,
   input wire op_kind_t cmd_kind_i,
   input wire logic [ADDR_W-1:0] cmd_addr_i,
   input wire logic [DATA_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   input wire logic reset_req_i,
   output logic done_o,
   output logic busy_o
);

   typedef enum logic [2:0] {H_IDLE, H_RST_LOW, H_RST_WAIT, H_WRITE, H_READ} host_state_t;

   host_state_t state;
   op_kind_t kind;
   logic [ADDR_W-1:0] arg_addr;
   logic [DATA_W-1:0] arg_data;
   logic [2:0] step;
   logic [2:0] idx;
   logic [7:0] ph;
   logic [7:0] wait_cnt;
   logic second;
   logic prev_bit;
   logic [DATA_W-1:0] rd_meta;
   logic [DATA_W-1:0] rd_s;
   logic [ADDR_W-1:0] seq_addr;
   logic [DATA_W-1:0] seq_data;
   logic last_word;
   logic step_end;
   logic [ADDR_W-1:0] ul1_addr;
   logic [ADDR_W-1:0] ul2_addr;

   // ==========================================================
   // Sequence words per command
   always_comb begin
      // Upper bits follow the target word, so the device must ignore them
      ul1_addr = {arg_addr[ADDR_W-1:UNLOCK_W], UL_ADDR1};
      ul2_addr = {arg_addr[ADDR_W-1:UNLOCK_W], UL_ADDR2};
      seq_addr = ul1_addr;
      seq_data = UL_DATA1;
      unique case (idx)
         3'h1, 3'h4: begin
            seq_addr = ul2_addr;
            seq_data = UL_DATA2;
         end
         3'h2: seq_data = (kind == OP_PROG) ? CMD_PROG : CMD_ERASE;
         3'h3: begin
            if (kind == OP_PROG) begin
               seq_addr = arg_addr;
               seq_data = arg_data;
            end
         end
         3'h5: begin
            seq_addr = (kind == OP_SECT) ? arg_addr : ul1_addr;
            seq_data = (kind == OP_SECT) ? CMD_SECT : CMD_CHIP;
         end
         default: ;
      endcase
      last_word = (kind == OP_PROG) ? (idx == 3'h3) : (idx == 3'h5);
      step_end = ph == 8'(STEP_TIME_CYC - 1);
      cmd_ready_o = state == H_IDLE && !reset_req_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_meta <= '0;
         rd_s <= '0;
      end else begin
         rd_meta <= bus.rdata;
         rd_s <= rd_meta;
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= H_IDLE;
         kind <= OP_PROG;
         arg_addr <= '0;
         arg_data <= '0;
         step <= '0;
         idx <= '0;
         ph <= '0;
         wait_cnt <= '0;
         second <= 1'b0;
         prev_bit <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         ph <= step_end ? 8'h0 : ph + 8'h1;
         if (step_end) step <= step + 3'h1;
         unique case (state)
            H_IDLE: begin
               ph <= '0;
               step <= '0;
               if (reset_req_i) begin
                  state <= H_RST_LOW;
                  wait_cnt <= '0;
               end else if (cmd_valid_i) begin
                  state <= H_WRITE;
                  kind <= cmd_kind_i;
                  arg_addr <= cmd_addr_i;
                  arg_data <= cmd_data_i;
                  idx <= '0;
               end
            end
            H_RST_LOW: begin
               wait_cnt <= wait_cnt + 8'h1;
               if (wait_cnt == 8'(RST_PULSE_CYC - 1)) begin
                  state <= H_RST_WAIT;
                  wait_cnt <= '0;
               end
            end
            H_RST_WAIT: begin
               wait_cnt <= wait_cnt + 8'h1;
               if (wait_cnt == 8'(RST_HIGH_CYC - 1)) state <= H_IDLE;
            end
            H_WRITE: begin
               if (step_end && step == 3'h4) begin
                  step <= '0;
                  idx <= idx + 3'h1;
                  if (last_word) begin
                     state <= H_READ;
                     second <= 1'b0;
                  end
               end
            end
            H_READ: begin
               if (step_end && step == 3'h4) begin
                  step <= '0;
                  second <= !second;
                  prev_bit <= rd_s[STATUS_TOGGLE_BIT];
                  if (second && prev_bit == rd_s[STATUS_TOGGLE_BIT]) begin
                     state <= H_IDLE;
                     done_o <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Pin levels, registered; select rises after each cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         bus.cs_n <= 1'b1;
         bus.addr_valid_strobe_n <= 1'b1;
         bus.we_n <= 1'b1;
         bus.oe_n <= 1'b1;
         bus.flash_clk <= 1'b0;
         bus.reset_n <= 1'b1;
         bus.addr <= '0;
         bus.wdata <= '0;
         busy_o <= 1'b0;
      end else begin
         busy_o <= state != H_IDLE;
         bus.reset_n <= state != H_RST_LOW;
         bus.cs_n <= !((state == H_WRITE || state == H_READ) && step != 3'h4);
         // New strobe pulse per bus cycle, unlock cycles included
         // Writes keep it low through the clock step so that edge latches first
         bus.addr_valid_strobe_n <= !((state == H_WRITE && step <= 3'h1)
            || (state == H_READ && step == 3'h0));
         // Clock pulses only with the strobe low and write high
         bus.flash_clk <= sync_mode_i && state == H_WRITE && step == 3'h1;
         bus.we_n <= !(state == H_WRITE && step == 3'h2);
         bus.oe_n <= !(state == H_READ && (step == 3'h2 || step == 3'h3));
         if (state == H_WRITE) begin
            bus.addr <= seq_addr;
            bus.wdata <= seq_data;
         end else if (state == H_READ) begin
            bus.addr <= arg_addr;
         end
      end
   end

endmodule // flash_host
`default_nettype wire

/* tb/flash_link_chk.sv */
// Concurrent checks on the flash bus pins between host and device
`timescale 1ns/1ns
`default_nettype none
module flash_link_chk (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic cs_n,
   input wire logic addr_valid_strobe_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic flash_clk,
   input wire logic reset_n,
   input wire logic [15:0] rdata
);
   // ==========================================================
   // Properties
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   a_no_clk_write: assert property (!we_n |-> !$rose(flash_clk))
      else $error("bus clock edge while write strobe low");
   a_strobe_per_write: assert property ($fell(we_n) |-> $rose(addr_valid_strobe_n) && !cs_n)
      else $error("write strobe without address strobe toggle");
   a_write_ends_deselect: assert property ($rose(we_n) |-> ##[1:8] $rose(cs_n))
      else $error("no deselect after write cycle");
   a_reset_pulse_min: assert property ($fell(reset_n) |-> !reset_n [*8])
      else $error("reset pin pulse too short");
   a_read_after_reset: assert property ($rose(reset_n) |-> oe_n [*4])
      else $error("read started too soon after reset");
   a_status_strobe: assert property ($fell(oe_n) |-> addr_valid_strobe_n && !cs_n && we_n)
      else $error("status read without fresh address strobe");
   a_clk_in_cycle: assert property ($rose(flash_clk) |-> !cs_n && !addr_valid_strobe_n)
      else $error("bus clock edge outside an address phase");
   a_status_bits_only: assert property ((rdata & 16'hffbf) == 16'h0000)
      else $error("status word carries more than the toggle bit");
endmodule // flash_link_chk
`default_nettype wire

/* tb/flash_write_cycle_and_reset_interface_test.sv */
// Self-checking testbench joining the flash host and device ends
`timescale 1ns/1ns
`default_nettype none
module flash_write_cycle_and_reset_interface_test;
   import flash_pkg::*;
   // Short counts keep the run small; standby below the reset pulse so it is reached
   localparam int PROG_T = 20;
   localparam int SECT_T = 200;
   localparam int CHIP_T = 80;
   localparam int STBY_T = 8;
   logic ref_clk_i, rst_i, host_kill, host_rst, sync_mode, cmd_valid, reset_req;
   op_kind_t cmd_kind, op_kind;
   logic [ADDR_W-1:0] cmd_addr, op_addr;
   logic [DATA_W-1:0] cmd_data, op_data;
   logic cmd_ready, h_done, h_busy, d_busy, read_mode, standby, op_start, op_done, op_abort;
   int n_fail, checks_done;
   assign host_rst = rst_i | host_kill;

   flash_if bus();
   flash_host #(.STEP_TIME_CYC(STEP_CYC)) u_flash_host (.ref_clk_i(ref_clk_i), .rst_i(host_rst),
      .bus(bus), .sync_mode_i(sync_mode), .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind),
      .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
      .reset_req_i(reset_req), .done_o(h_done), .busy_o(h_busy));
   flash_dev #(.PROG_TIME_CYC(PROG_T), .SECT_TIME_CYC(SECT_T), .CHIP_TIME_CYC(CHIP_T),
      .STANDBY_TIME_CYC(STBY_T)) u_flash_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus),
      .sync_mode_i(sync_mode), .busy_o(d_busy), .read_mode_o(read_mode), .standby_o(standby),
      .op_start_o(op_start), .op_done_o(op_done), .op_abort_o(op_abort), .op_kind_o(op_kind),
      .op_addr_o(op_addr), .op_data_o(op_data));
   flash_link_chk u_flash_link_chk (.ref_clk_i(ref_clk_i), .rst_i(host_rst), .cs_n(bus.cs_n),
      .addr_valid_strobe_n(bus.addr_valid_strobe_n), .we_n(bus.we_n), .oe_n(bus.oe_n),
      .flash_clk(bus.flash_clk), .reset_n(bus.reset_n), .rdata(bus.rdata));

   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   // ==========================================================
   // Shared helpers
   task automatic give_verdict;
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic hit(input int sel);
      case (sel)
         0: hit = op_start;
         1: hit = cmd_ready;
         2: hit = h_done;
         3: hit = op_abort;
         4: hit = standby;
         5: hit = ~bus.reset_n;
         default: hit = ~h_busy;
      endcase
   endfunction

   // Bounded wait sampled at falling edges, where registered outputs are settled
   task automatic wait_for(input int sel, input int lim, output int n);
      n = 0;
      while (hit(sel) !== 1'b1 && n < lim) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n >= lim) begin
         n_fail++;
         $display("Error wait %0d timed out", sel);
         give_verdict();
      end
   endtask

   task automatic issue(input op_kind_t k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      wait_for(1, 100, n);
      cmd_kind = k;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge ref_clk_i);
      cmd_valid = 1'b0;
   endtask

   task automatic run_op(input op_kind_t k, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] exp_d, input int t, input bit use_a);
      int n;
      int nd;
      issue(k, a, d);
      wait_for(0, 2000, n);
      check("op kind", 32'(op_kind), 32'(k));
      if (use_a) begin
         check("op address", 32'(op_addr), 32'(a));
      end
      check("op word", 32'(op_data), 32'(exp_d));
      n = 0;
      nd = 0;
      // Busy flag lags the start pulse by one cycle
      @(negedge ref_clk_i);
      while (d_busy === 1'b1 && n < t + 10) begin
         @(negedge ref_clk_i);
         n++;
         if (op_done === 1'b1) nd++;
      end
      check("busy length", 32'(n >= t - 1 && n <= t + 2), 32'h1);
      check("done pulses", 32'(nd), 32'h1);
      wait_for(2, 1000, n);
      check("read mode after op", 32'(read_mode), 32'h1);
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_program;
      sync_mode = 1'b0;
      run_op(OP_PROG, 21'h1f0123, 16'h5a3c, 16'h5a3c, PROG_T, 1'b1);
      sync_mode = 1'b1;
      run_op(OP_PROG, 21'h0ff555, 16'ha5c3, 16'ha5c3, PROG_T, 1'b1);
      run_op(OP_PROG, 21'h100000, 16'h0001, 16'h0001, PROG_T, 1'b1);
      $display("test program done");
   endtask

   task automatic test_erase;
      sync_mode = 1'b0;
      run_op(OP_SECT, 21'h0a4000, 16'h0000, CMD_SECT, SECT_T, 1'b1);
      sync_mode = 1'b1;
      run_op(OP_CHIP, 21'h000000, 16'h0000, CMD_CHIP, CHIP_T, 1'b0);
      $display("test erase done");
   endtask

   task automatic test_reset_idle;
      int n;
      reset_req = 1'b1;
      @(negedge ref_clk_i);
      reset_req = 1'b0;
      wait_for(5, 50, n);
      wait_for(4, 40, n);
      check("standby delay", 32'(n >= STBY_T && n <= STBY_T + 4), 32'h1);
      check("read mode idle reset", 32'(read_mode), 32'h1);
      check("busy idle reset", 32'(d_busy), 32'h0);
      wait_for(6, 100, n);
      check("standby left", 32'(standby), 32'h0);
      $display("test reset idle done");
   endtask

   task automatic test_abort;
      int n;
      sync_mode = 1'b0;
      issue(OP_SECT, 21'h1c0000, 16'h0000);
      wait_for(0, 2000, n);
      host_kill = 1'b1;
      @(negedge ref_clk_i);
      host_kill = 1'b0;
      wait_for(1, 20, n);
      reset_req = 1'b1;
      @(negedge ref_clk_i);
      reset_req = 1'b0;
      wait_for(5, 50, n);
      wait_for(3, 10, n);
      check("abort latency", 32'(n <= 4), 32'h1);
      @(negedge ref_clk_i);
      check("busy after abort", 32'(d_busy), 32'h0);
      check("read mode after abort", 32'(read_mode), 32'h1);
      wait_for(6, 100, n);
      $display("test abort done");
   endtask

   initial begin
      n_fail = 0;
      checks_done = 0;
      rst_i = 1'b1;
      host_kill = 1'b0;
      sync_mode = 1'b0;
      cmd_valid = 1'b0;
      reset_req = 1'b0;
      cmd_kind = OP_PROG;
      cmd_addr = 21'h000000;
      cmd_data = 16'h0000;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      test_program();
      test_erase();
      test_reset_idle();
      test_abort();
      give_verdict();
   end
endmodule // flash_write_cycle_and_reset_interface_test
`default_nettype wire
